// >>> hdl/clkpm_defines.svh
// constants for the clock prescaler and sleep manager
// assumes a 200 MHz master clock and a byte-wide register port
`ifndef CLKPM_DEFINES_SVH
`define CLKPM_DEFINES_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define ADDR_PRESCALE 8'h00
`define ADDR_SLEEP 8'h01
`define ADDR_CORE 8'h02
`define ADDR_STATUS 8'h03

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define PCE_BIT 7
`define BROWNOUT_SLEEP_DISABLE_BIT 6
`define BODSE_BIT 5
`define SE_BIT 0
`define PCE_KEY 8'h80
`define BROWNOUT_SLEEP_DISABLE_KEY 8'h60
`define PS_RESET_DIV1 4'h0
`define PS_RESET_DIV8 4'h3
`define PS_MAX 4'h8

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define PCE_WINDOW 3'd4
`define BODSE_WINDOW 3'd4
`define HALT_CYCLES 16'd4
`define STANDBY_WAKE_CYCLES 16'd6
`define CLK_FREQ_MHZ 200
`define BOD_WAKE_US 60

`endif

// >>> hdl/clkpm_pkg.sv
// types shared by the clock prescaler and sleep manager
// assumes clkpm_defines.svh for all numeric constants
package clkpm_pkg;

	// ------------------------------------------------------------
	// sleep modes and manager states
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		MODE_IDLE = 3'b000,
		MODE_ADC_QUIET = 3'b001,
		MODE_POWER_DOWN = 3'b010,
		MODE_POWER_SAVE = 3'b011,
		MODE_RSVD4 = 3'b100,
		MODE_RSVD5 = 3'b101,
		MODE_STANDBY = 3'b110,
		MODE_EXT_STANDBY = 3'b111
	} sleep_mode_e;

	typedef enum logic [1:0] {
		PM_ACTIVE = 2'b00,
		PM_SLEEP = 2'b01,
		PM_WAKE = 2'b10
	} pm_state_e;

	// ------------------------------------------------------------
	// wake sources and clock domain enables
	// ------------------------------------------------------------
	typedef struct packed {
		logic extLevel;
		logic extEdge;
		logic pinChange;
		logic twiMatch;
		logic timer2;
		logic memReady;
		logic adcDone;
		logic watchdog;
		logic otherIo;
	} wake_src_s;

	typedef struct packed {
		logic cpu;
		logic flash;
		logic io;
		logic adc;
		logic async;
	} clk_domains_s;

	typedef struct packed {
		logic pce;
		logic [2:0] pceCnt;
		logic [3:0] ps;
		logic sleepArm;
		sleep_mode_e sleepMode;
		logic brownout_sleep_disable;
		logic bodse;
		logic [2:0] bodseCnt;
		pm_state_e pmState;
		sleep_mode_e curMode;
		logic bodsOff;
		logic [15:0] wakeCnt;
		logic [7:0] rdData;
		logic adcStart;
	} pm_regs_s;

endpackage : clkpm_pkg

// >>> hdl/pulse_divider.sv
// power-of-two divider giving a one-cycle enable pulse
// assumes shift changes only through the owner's register path
`include "clkpm_defines.svh"

module pulse_divider
	import clkpm_pkg::*;
#(
	parameter int WIDTH = 8
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic [3:0] shift,
	input wire logic [3:0] initShift,
	output logic tick
);

	typedef struct packed {
		logic [WIDTH-1:0] cnt;
		logic [3:0] activeShift;
	} div_s;

	div_s st_reg;
	div_s st_next;
	logic [WIDTH-1:0] limit;

	// ------------------------------------------------------------
	// counter; a new shift is taken only at a period boundary
	// ------------------------------------------------------------
	always_comb begin
		limit = WIDTH'((1 << st_reg.activeShift) - 1);
		tick = (st_reg.cnt == limit);
		st_next = st_reg;
		if (tick) begin
			st_next.cnt = '0;
			// reserved codes clamp to the largest division
			st_next.activeShift = (shift > `PS_MAX) ? `PS_MAX : shift;
		end else begin
			st_next.cnt = st_reg.cnt + 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			st_reg.cnt <= '0;
			st_reg.activeShift <= initShift;
		end else begin
			st_reg <= st_next;
		end
	end

	AST_TICK_SPACING: assert property (@(posedge clk) disable iff (srst)
		tick && st_next.activeShift != 4'h0 |=> !tick)
		else $error("divider ticked twice in a row");

endmodule : pulse_divider

// >>> hdl/clock_prescaler_sleep_manager.sv
// system clock prescaler and sleep mode manager
// assumes the core issues a one-cycle sleep pulse and register strobes
//
// Overview of operation
// - prescaler select changes only after the change enable bit is set
// - change enable updates only when all other bits are written zero
// - change enable self-clears after four divided ticks or on a select write
// - rewriting change enable in its window neither extends nor clears it
// - select field divides by two to the power of its value, up to 256
// - reset loads select 0011 with divide-by-eight fuse, else 0000
// - after reset any select value is accepted via the sequence
// - one divided tick clocks CPU and every synchronous peripheral
// - sleep entered only with sleep arm set and a sleep instruction
// - interrupt wake holds CPU four cycles beyond start-up, then resumes
// - reset during sleep wakes the device to the reset vector
// - sleep entry and exit leave register file and SRAM untouched
// - brownout sleep disable bit turns detector off in deep modes
// - detector off right after sleep entry, back on at wake-up
// - wake-up stretched to about 60 us when detector was off
// - brownout sleep disable written only through a timed enable sequence
// - idle stops only CPU and flash clocks, everything else runs
// - ADC quiet mode stops I/O, CPU, flash; ADC auto-starts there and idle
// - ADC quiet mode wakes only on its listed sources
// - power-down stops oscillator and clocks; wakes on async sources only
// - power-down wake waits the fuse-defined start-up delay
// - power-save is power-down plus running timer 2 and its wake-up
// - standby modes keep oscillator running and wake in six cycles
// - prescaler switches glitch-free with no faster intermediate rate
`include "clkpm_defines.svh"

module clock_prescaler_sleep_manager
	import clkpm_pkg::*;
#(
	parameter int BOD_WAKE_CYCLES = `BOD_WAKE_US * `CLK_FREQ_MHZ
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [7:0] regRdata,
	input wire logic initialDivideByEightFuse,
	input wire logic [15:0] startupCycles,
	input wire logic sleepInstr,
	input wire logic adcEnabled,
	input wire wake_src_s wakeSrc,
	output logic cpuClkEn,
	output logic flashClkEn,
	output logic ioClkEn,
	output logic adcClkEn,
	output logic asyncClkEn,
	output logic oscEnable,
	output logic brownoutDetectorEnable,
	output logic cpuHold,
	output logic adcAutoStart,
	output logic [1:0] pmStateOut
);

	pm_regs_s st_reg;
	pm_regs_s st_next;
	logic sysTick;
	logic [3:0] initPs;
	logic wrPrescale;
	logic wrSleep;
	logic wrCore;
	logic wakeHit;
	logic deepMode;
	logic [31:0] baseDelay;
	logic [31:0] wakeTotal;
	clk_domains_s dom;

	// ------------------------------------------------------------
	// wake source masks per sleep mode
	// ------------------------------------------------------------
	function automatic wake_src_s wake_mask(sleep_mode_e m);
		wake_src_s w;
		w = '0;
		case (m)
			MODE_ADC_QUIET: begin
				w = '1;
				w.otherIo = 1'b0;
				w.extEdge = 1'b0;
			end
			MODE_POWER_DOWN, MODE_STANDBY: begin
				w.extLevel = 1'b1;
				w.extEdge = 1'b1;
				w.pinChange = 1'b1;
				w.twiMatch = 1'b1;
				w.watchdog = 1'b1;
			end
			MODE_POWER_SAVE, MODE_EXT_STANDBY: begin
				w.extLevel = 1'b1;
				w.extEdge = 1'b1;
				w.pinChange = 1'b1;
				w.twiMatch = 1'b1;
				w.watchdog = 1'b1;
				w.timer2 = 1'b1;
			end
			default: begin
				w = '1;
			end
		endcase
		return w;
	endfunction : wake_mask

	function automatic logic is_deep(sleep_mode_e m);
		return (m == MODE_POWER_DOWN) || (m == MODE_POWER_SAVE) ||
			(m == MODE_STANDBY) || (m == MODE_EXT_STANDBY);
	endfunction : is_deep

	// ------------------------------------------------------------
	// divider
	// ------------------------------------------------------------
	assign initPs = initialDivideByEightFuse ? `PS_RESET_DIV8 :
		`PS_RESET_DIV1;

	pulse_divider #(
		.WIDTH(8)
	) u_div (
		.clk(clk),
		.srst(srst),
		.shift(st_reg.ps),
		.initShift(initPs),
		.tick(sysTick)
	);

	// ------------------------------------------------------------
	// decode and wake timing
	// ------------------------------------------------------------
	assign wrPrescale = regWrite && (regAddr == `ADDR_PRESCALE);
	assign wrSleep = regWrite && (regAddr == `ADDR_SLEEP);
	assign wrCore = regWrite && (regAddr == `ADDR_CORE);
	assign wakeHit = |(wakeSrc & wake_mask(st_reg.curMode));
	assign deepMode = is_deep(st_reg.curMode);

	always_comb begin
		baseDelay = 32'd0;
		if (st_reg.curMode == MODE_POWER_DOWN ||
			st_reg.curMode == MODE_POWER_SAVE) begin
			baseDelay = {16'h0000, startupCycles};
		end else if (st_reg.curMode == MODE_STANDBY ||
			st_reg.curMode == MODE_EXT_STANDBY) begin
			baseDelay = {16'h0000, `STANDBY_WAKE_CYCLES};
		end
		wakeTotal = baseDelay + {16'h0000, `HALT_CYCLES};
		if (st_reg.bodsOff && wakeTotal < 32'(BOD_WAKE_CYCLES)) begin
			wakeTotal = 32'(BOD_WAKE_CYCLES);
		end
	end

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		st_next = st_reg;
		st_next.rdData = 8'h00;
		st_next.adcStart = 1'b0;
		// change enable window counts divided ticks
		if (st_reg.pce && sysTick) begin
			st_next.pceCnt = st_reg.pceCnt + 3'd1;
			if (st_reg.pceCnt == `PCE_WINDOW - 3'd1) begin
				st_next.pce = 1'b0;
			end
		end
		if (st_reg.bodse && sysTick) begin
			st_next.bodseCnt = st_reg.bodseCnt + 3'd1;
			if (st_reg.bodseCnt == `BODSE_WINDOW - 3'd1) begin
				st_next.bodse = 1'b0;
			end
		end
		if (wrPrescale) begin
			if (regWdata == `PCE_KEY) begin
				if (!st_reg.pce) begin
					st_next.pce = 1'b1;
					st_next.pceCnt = 3'd0;
				end else begin
					st_next.pce = st_next.pce;
				end
			end else if (!regWdata[`PCE_BIT] && st_reg.pce) begin
				st_next.ps = regWdata[3:0];
				st_next.pce = 1'b0;
			end
		end
		if (wrSleep) begin
			st_next.sleepArm = regWdata[`SE_BIT];
			st_next.sleepMode = sleep_mode_e'(regWdata[3:1]);
		end
		if (wrCore) begin
			if (regWdata[`BROWNOUT_SLEEP_DISABLE_BIT] && regWdata[`BODSE_BIT]) begin
				st_next.bodse = 1'b1;
				st_next.bodseCnt = 3'd0;
			end else if (st_reg.bodse && !regWdata[`BODSE_BIT]) begin
				st_next.brownout_sleep_disable = regWdata[`BROWNOUT_SLEEP_DISABLE_BIT];
				st_next.bodse = 1'b0;
			end
		end
		if (regRead) begin
			case (regAddr)
				`ADDR_PRESCALE: st_next.rdData = {st_reg.pce, 3'b000, st_reg.ps};
				`ADDR_SLEEP: st_next.rdData = {4'h0, st_reg.sleepMode,
					st_reg.sleepArm};
				`ADDR_CORE: st_next.rdData = {1'b0, st_reg.brownout_sleep_disable,
					st_reg.bodse, 5'h00};
				`ADDR_STATUS: st_next.rdData = {1'b0, st_reg.curMode,
					st_reg.bodsOff, 1'b0, st_reg.pmState};
				default: st_next.rdData = 8'h00;
			endcase
		end
		// working registers and SRAM are outside and never touched
		case (st_reg.pmState)
			PM_ACTIVE: begin
				if (sleepInstr && st_reg.sleepArm) begin
					st_next.pmState = PM_SLEEP;
					st_next.curMode = st_reg.sleepMode;
					st_next.bodsOff = st_reg.brownout_sleep_disable &&
						is_deep(st_reg.sleepMode);
					st_next.adcStart = adcEnabled &&
						(st_reg.sleepMode == MODE_IDLE ||
						st_reg.sleepMode == MODE_ADC_QUIET);
				end
			end
			PM_SLEEP: begin
				if (wakeHit) begin
					st_next.pmState = PM_WAKE;
					st_next.wakeCnt = 16'(wakeTotal - 32'd1);
				end
			end
			PM_WAKE: begin
				if (st_reg.wakeCnt == 16'd0) begin
					st_next.pmState = PM_ACTIVE;
					st_next.bodsOff = 1'b0;
				end else begin
					st_next.wakeCnt = st_reg.wakeCnt - 16'd1;
				end
			end
			default: begin
				st_next.pmState = PM_ACTIVE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			st_reg <= '0;
			st_reg.ps <= initPs;
			st_reg.sleepMode <= MODE_IDLE;
			st_reg.curMode <= MODE_IDLE;
			st_reg.pmState <= PM_ACTIVE;
		end else begin
			st_reg <= st_next;
		end
	end

	// ------------------------------------------------------------
	// clock domains and outputs
	// ------------------------------------------------------------
	always_comb begin
		dom = '1;
		if (st_reg.pmState != PM_ACTIVE) begin
			dom.cpu = 1'b0;
			dom.flash = 1'b0;
			case (st_reg.curMode)
				MODE_ADC_QUIET: begin
					dom.io = 1'b0;
				end
				MODE_POWER_DOWN, MODE_STANDBY: begin
					dom = '0;
				end
				MODE_POWER_SAVE, MODE_EXT_STANDBY: begin
					dom.io = 1'b0;
					dom.adc = 1'b0;
				end
				default: begin
					dom.io = 1'b1;
				end
			endcase
		end
	end

	assign cpuClkEn = sysTick && dom.cpu;
	assign flashClkEn = sysTick && dom.flash;
	assign ioClkEn = sysTick && dom.io;
	assign adcClkEn = sysTick && dom.adc;
	assign asyncClkEn = sysTick && dom.async;
	assign oscEnable = (st_reg.pmState != PM_SLEEP) ||
		!(st_reg.curMode == MODE_POWER_DOWN ||
		st_reg.curMode == MODE_POWER_SAVE);
	assign brownoutDetectorEnable = !(st_reg.pmState == PM_SLEEP &&
		st_reg.bodsOff);
	assign cpuHold = (st_reg.pmState != PM_ACTIVE);
	assign adcAutoStart = st_reg.adcStart;
	assign regRdata = st_reg.rdData;
	assign pmStateOut = st_reg.pmState;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	sequence seq_key_write;
		wrPrescale && regWdata == `PCE_KEY;
	endsequence

	sequence seq_idle_wake;
		st_reg.pmState == PM_SLEEP && st_reg.curMode == MODE_IDLE &&
			wakeHit && !st_reg.bodsOff;
	endsequence

	sequence seq_standby_wake;
		st_reg.pmState == PM_SLEEP && st_reg.curMode == MODE_STANDBY &&
			wakeHit && !st_reg.bodsOff;
	endsequence

	AST_PCE_TIMEOUT: assert property (@(posedge clk) disable iff (srst)
		st_reg.pce && sysTick && st_reg.pceCnt == 3'd3 |=> !st_reg.pce)
		else $error("change enable outlived its window");

	AST_PCE_NO_RESTART: assert property (@(posedge clk) disable iff (srst)
		seq_key_write ##0 st_reg.pce |=>
		st_reg.pce == !($past(sysTick) && $past(st_reg.pceCnt) == 3'd3) &&
		st_reg.pceCnt == $past(st_reg.pceCnt) + 3'($past(sysTick)))
		else $error("rewrite of change enable disturbed its window");

	AST_PS_GUARD: assert property (@(posedge clk) disable iff (srst)
		wrPrescale && !st_reg.pce |=> st_reg.ps == $past(st_reg.ps))
		else $error("select changed without change enable");

	AST_PS_LOAD: assert property (@(posedge clk) disable iff (srst)
		wrPrescale && st_reg.pce && !regWdata[7] |=>
		st_reg.ps == $past(regWdata[3:0]) && !st_reg.pce)
		else $error("select write not taken");

	AST_PS_RESET: assert property (@(posedge clk)
		srst |=> st_reg.ps == ($past(initialDivideByEightFuse) ? 4'h3 : 4'h0))
		else $error("wrong select after reset");

	AST_SLEEP_ARM: assert property (@(posedge clk) disable iff (srst)
		st_reg.pmState == PM_ACTIVE && sleepInstr && !st_reg.sleepArm
		|=> st_reg.pmState == PM_ACTIVE)
		else $error("slept without sleep arm");

	AST_IDLE_WAKE: assert property (@(posedge clk) disable iff (srst)
		seq_idle_wake |=> cpuHold [*4] ##1 !cpuHold)
		else $error("idle wake not four held cycles");

	AST_STANDBY_WAKE: assert property (@(posedge clk) disable iff (srst)
		seq_standby_wake |=> st_reg.pmState == PM_WAKE ##10
		st_reg.pmState == PM_ACTIVE)
		else $error("standby wake not six plus four cycles");

	AST_BOD_OFF: assert property (@(posedge clk) disable iff (srst)
		st_reg.pmState == PM_SLEEP && st_reg.bodsOff |->
		!brownoutDetectorEnable ##0 !$past(brownoutDetectorEnable) ||
		$past(st_reg.pmState) == PM_ACTIVE)
		else $error("detector not off during sleep");

	AST_IDLE_CLOCKS: assert property (@(posedge clk) disable iff (srst)
		st_reg.pmState == PM_SLEEP && st_reg.curMode == MODE_IDLE |->
		!cpuClkEn && !flashClkEn && ioClkEn == sysTick)
		else $error("idle clocks wrong");

	AST_ADC_START: assert property (@(posedge clk) disable iff (srst)
		st_reg.pmState == PM_ACTIVE && sleepInstr && st_reg.sleepArm &&
		adcEnabled && st_reg.sleepMode == MODE_ADC_QUIET |=> adcAutoStart)
		else $error("ADC did not auto-start");

endmodule : clock_prescaler_sleep_manager

// >>> test/core_partner.sv
// model of the core and interrupt sources facing the manager
// assumes bench requests arrive as one-cycle pulses on clk
module core_partner
	import clkpm_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input wire logic sleepReq,
	input wire logic [8:0] irqSet,
	input wire logic [1:0] pmStateOut,
	output logic sleepInstr,
	output wake_src_s wakeSrc
);
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------------------------------
	// sleep instruction and held interrupt requests
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		sleepInstr <= sleepReq & ~srst;
		if (srst) begin
			wakeSrc <= '0;
		end else if (irqSet != 9'h000) begin
			wakeSrc <= wakeSrc | wake_src_s'(irqSet);
		end else if (pmStateOut == PM_WAKE) begin
			wakeSrc <= '0;
		end
	end
endmodule : core_partner

// >>> test/clock_prescaler_sleep_manager_test.sv
// self-checking bench for the prescaler and sleep manager
// assumes the design files and core_partner are compiled first
`include "clkpm_defines.svh"

module clock_prescaler_sleep_manager_test
	import clkpm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int BODW = 20;
	logic clk, srst, regWrite, regRead, fuse, sleepInstr, sleepReq;
	logic adcEnabled, cpuClkEn, flashClkEn, ioClkEn, adcClkEn;
	logic asyncClkEn, oscEnable, brownoutDetectorEnable, cpuHold;
	logic adcAutoStart;
	logic [7:0] regAddr, regWdata, regRdata, lastRd;
	logic [15:0] startupCycles;
	logic [8:0] irqSet;
	logic [1:0] pmStateOut;
	logic [3:0] cur;
	wake_src_s wakeSrc;
	int miscompares, compares, cycles, autoCnt;
	integer seed;

	clock_prescaler_sleep_manager #(.BOD_WAKE_CYCLES(BODW)) i_dut (
		.clk(clk), .srst(srst), .regAddr(regAddr), .regWdata(regWdata),
		.regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
		.initialDivideByEightFuse(fuse), .startupCycles(startupCycles),
		.sleepInstr(sleepInstr), .adcEnabled(adcEnabled),
		.wakeSrc(wakeSrc), .cpuClkEn(cpuClkEn), .flashClkEn(flashClkEn),
		.ioClkEn(ioClkEn), .adcClkEn(adcClkEn), .asyncClkEn(asyncClkEn),
		.oscEnable(oscEnable), .cpuHold(cpuHold),
		.brownoutDetectorEnable(brownoutDetectorEnable),
		.adcAutoStart(adcAutoStart), .pmStateOut(pmStateOut)
	);

	core_partner i_core (
		.clk(clk), .srst(srst), .sleepReq(sleepReq), .irqSet(irqSet),
		.pmStateOut(pmStateOut), .sleepInstr(sleepInstr), .wakeSrc(wakeSrc)
	);

	// ----------------------------------------------------------------
	// clock, timeout and helpers
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	always @(posedge clk) begin
		cycles++;
		if (adcAutoStart === 1'b1) autoCnt++;
		if (cycles == 20000) begin
			miscompares++;
			finish_test();
		end
	end

	task finish_test;
		if (miscompares == 0 && compares > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : finish_test

	task chkVal(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chkVal

	task chkMin(input logic [15:0] got, input logic [15:0] lo);
		compares++;
		if ((got >= lo) !== 1'b1) begin
			miscompares++;
			$display("ERROR at %0t: got %h below %h", $time, got, lo);
		end
	endtask : chkMin

	task bus(input logic w, input logic r, input logic [7:0] a,
		input logic [7:0] d);
		regWrite <= w;
		regRead <= r;
		regAddr <= a;
		regWdata <= d;
		@(posedge clk);
		lastRd = regRdata;
	endtask : bus

	task wr(input logic [7:0] a, input logic [7:0] d);
		bus(1'b1, 1'b0, a, d);
	endtask : wr

	task rd(input logic [7:0] a);
		bus(1'b0, 1'b1, a, 8'h00);
		bus(1'b0, 1'b0, 8'h00, 8'h00);
	endtask : rd

	task gap(output int g);
		int i;
		i = 0;
		while (cpuClkEn !== 1'b1 && i < 600) begin
			@(posedge clk);
			i++;
		end
		chkVal(ioClkEn, 16'h1);
		@(posedge clk);
		g = 1;
		while (cpuClkEn !== 1'b1 && g < 600) begin
			@(posedge clk);
			g++;
		end
	endtask : gap

	task setDiv(input logic [3:0] c);
		int g;
		wr(8'h00, 8'h80);
		wr(8'h00, {4'h0, c});
		rd(8'h00);
		chkVal(lastRd, {4'h0, c});
		gap(g);
		chkMin(16'(g), (c < cur) ? 16'h1 << c : 16'h1 << cur);
		gap(g);
		gap(g);
		chkVal(16'(g), 16'h1 << c);
		cur = c;
	endtask : setDiv

	function logic [5:0] expDom(input logic [2:0] m);
		case (m)
			3'h0: return 6'h0f;
			3'h1: return 6'h07;
			3'h3: return 6'h02;
			3'h6: return 6'h01;
			3'h7: return 6'h03;
			default: return 6'h00;
		endcase
	endfunction : expDom

	function logic [15:0] wakeLen(input logic [2:0] m, input logic [15:0] su);
		if (m == 3'h2 || m == 3'h3) return su + 16'h4;
		if (m[2:1] == 2'h3) return 16'ha;
		return 16'h4;
	endfunction : wakeLen

	task sleepCycle(input logic [2:0] m, input logic [8:0] noWake,
		input logic expBod);
		int n, a0;
		logic [15:0] su;
		su = 16'h8 + 16'($unsigned($random(seed)) % 32);
		startupCycles <= su;
		adcEnabled <= 1'($random(seed));
		a0 = autoCnt;
		wr(8'h01, {4'h0, m, 1'b1});
		sleepReq <= 1'b1;
		bus(1'b0, 1'b0, 8'h00, 8'h00);
		sleepReq <= 1'b0;
		n = 0;
		while (pmStateOut !== PM_SLEEP && n < 8) begin
			@(posedge clk);
			n++;
		end
		repeat (2) @(posedge clk);
		chkVal({cpuClkEn, flashClkEn, ioClkEn, adcClkEn, asyncClkEn,
			oscEnable}, expDom(m));
		chkVal({brownoutDetectorEnable, cpuHold}, {expBod, 1'b1});
		chkVal(16'(autoCnt - a0), adcEnabled & (m < 3'h2));
		if (noWake != 9'h000) begin
			irqSet <= noWake;
			@(posedge clk);
			irqSet <= 9'h000;
			repeat (10) @(posedge clk);
			chkVal(pmStateOut, PM_SLEEP);
		end
		irqSet <= 9'h002;
		@(posedge clk);
		irqSet <= 9'h000;
		n = 0;
		while (pmStateOut !== PM_WAKE && n < 20) begin
			@(posedge clk);
			n++;
		end
		chkVal(cpuHold, 16'h1);
		n = 0;
		while (pmStateOut === PM_WAKE && n < 2000) begin
			@(posedge clk);
			n++;
		end
		if (expBod) chkVal(16'(n), wakeLen(m, su));
		else chkVal(16'(n), (wakeLen(m, su) > 16'(BODW)) ?
			wakeLen(m, su) : 16'(BODW));
		chkVal({pmStateOut, cpuHold, brownoutDetectorEnable}, 16'h1);
	endtask : sleepCycle

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		int i;
		seed = 32'h8f21ac02;
		srst = 1'b1;
		fuse = 1'b1;
		regWrite = 1'b0;
		regRead = 1'b0;
		regAddr = 8'h00;
		regWdata = 8'h00;
		startupCycles = 16'h8;
		sleepReq = 1'b0;
		adcEnabled = 1'b0;
		irqSet = 9'h000;
		cur = 4'h3;
		repeat (20) @(posedge clk);
		srst <= 1'b0;
		rd(8'h00);
		chkVal(lastRd, 16'h03);
		wr(8'h00, 8'h02);
		wr(8'h00, 8'h81);
		rd(8'h00);
		chkVal(lastRd, 16'h03);
		wr(8'h10, 8'hff);
		rd(8'h10);
		chkVal(lastRd, 16'h00);
		wr(8'h00, 8'h80);
		bus(1'b0, 1'b0, 8'h00, 8'h00);
		wr(8'h00, 8'h80);
		rd(8'h00);
		chkVal(lastRd, 16'h83);
		repeat (40) @(posedge clk);
		rd(8'h00);
		chkVal(lastRd, 16'h03);
		for (i = 0; i < 9; i++) setDiv(4'((i * 5) % 9));
		i = 9 + ($unsigned($random(seed)) % 7);
		wr(8'h00, 8'h80);
		wr(8'h00, 8'(i));
		rd(8'h00);
		chkVal(lastRd, 16'(i));
		cur = 4'h8;
		setDiv(4'h0);
		rd(8'h02);
		chkVal(lastRd, 16'h00);
		wr(8'h02, 8'h40);
		rd(8'h02);
		chkVal(lastRd, 16'h00);
		for (i = 0; i < 8; i++) begin
			if (i != 4 && i != 5)
				sleepCycle(3'(i), (i == 0) ? 9'h000 : (i == 1) ? 9'h001 :
					9'h008, 1'b1);
		end
		wr(8'h02, 8'h60);
		wr(8'h02, 8'h40);
		repeat (6) bus(1'b0, 1'b0, 8'h00, 8'h00);
		rd(8'h02);
		chkVal(lastRd, 16'h40);
		sleepCycle(3'h0, 9'h000, 1'b1);
		sleepCycle(3'h2, 9'h008, 1'b0);
		wr(8'h01, 8'h00);
		sleepReq <= 1'b1;
		bus(1'b0, 1'b0, 8'h00, 8'h00);
		sleepReq <= 1'b0;
		repeat (4) @(posedge clk);
		chkVal(pmStateOut, PM_ACTIVE);
		wr(8'h01, 8'h05);
		sleepReq <= 1'b1;
		bus(1'b0, 1'b0, 8'h00, 8'h00);
		sleepReq <= 1'b0;
		repeat (4) @(posedge clk);
		chkVal(pmStateOut, PM_SLEEP);
		srst <= 1'b1;
		fuse <= 1'b0;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		chkVal({pmStateOut, cpuHold, oscEnable}, 16'h1);
		rd(8'h00);
		chkVal(lastRd, 16'h00);
		finish_test();
	end
endmodule : clock_prescaler_sleep_manager_test
